/* File: adc_ctrl_params.svh */
// Behaviour
// - Enable bit powers converter up or down
// - Disabling mid-conversion aborts it, no result
// - Single mode: each start write, one conversion
// - Free running: one start, then continuous
// - Thirteen converter cycles; first after enable 25
// - Start reads one while busy; zero-write ignored
// - Auto trigger starts on selected rising edge
// - Done flag set when result updated; the code also sets it when a locked result register keeps the old value
// - Interrupt when flag, local, global enables set
// - Flag cleared by vector or one-write
// - Divider codes: 2,2,4,8,16,32,64,128
// - Right alignment: bits 9..8 in high low-bits
// - Left alignment: bits 9..2 high, 1..0 top-low
// - Differential inputs give two's complement result
// - Low byte read locks until high read
// - Source field ignored without auto trigger
// - Source switch cleared-to-set counts as edge
// - Switching to free running makes no trigger
// - Source codes: free, comparator, ext0, timers...
// - Input/reference changes apply after completion
// - Alignment change affects result view immediately
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

`define OFS_CTRL_STATUS_A 8'h00
`define OFS_RESULT_LOW 8'h04
`define OFS_RESULT_HIGH 8'h08
`define OFS_SPECIAL_FUNC 8'h0C
`define OFS_INPUT_REF_SEL 8'h10

`define BIT_ENABLE 7
`define BIT_START 6
`define BIT_AUTO 5
`define BIT_FLAG 4
`define BIT_IRQ_EN 3
`define BIT_LEFT_ALIGN 5

`define RESET_CTRL_STATUS_A 8'h00
`define RESET_INPUT_REF_SEL 8'h00
`define RESET_SPECIAL_FUNC 8'h00
`define RESET_RESULT 10'h000

`define CONV_TICKS_NORMAL 5'h0D
`define CONV_TICKS_FIRST 5'h19
`define TRIG_FREE_RUNNING 3'h0
`define DIFF_INPUT_FIRST 5'h08
`define DIFF_INPUT_LAST 5'h1D

`endif

/* File: adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } conv_state_t;

  typedef logic [2:0] trig_sel_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } div_state_t;

  typedef struct packed {
    logic prev;
    logic pulse;
  } trig_state_t;

  typedef struct packed {
    conv_state_t state;
    logic en;
    logic busy;
    logic auto_trig;
    logic flag;
    logic irq_en;
    logic [2:0] div_sel;
    logic left;
    logic [1:0] ref_sel;
    logic [4:0] in_sel;
    trig_sel_t trig_sel;
    logic [4:0] sf_low;
    logic [1:0] act_ref;
    logic [4:0] act_in;
    logic first;
    logic long_conv;
    logic [4:0] cnt;
    logic [9:0] result;
    logic lock;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic start_pulse;
  } ctrl_state_t;

endpackage

/* File: adc_clock_divider.sv */
`timescale 1ns/10ps
module adc_clock_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic tick
);
  import adc_ctrl_pkg::*;

  div_state_t q;
  div_state_t d;
  logic [6:0] last;

  always_comb
  begin
    d = q;
    d.tick = 1'h0;
    // Codes 0 and 1 both divide by two
    last = (div_sel < 3'h2) ? 7'h01 : 7'((8'h01 << div_sel) - 8'h01);
    if (!run)
      d.cnt = 7'h00;
    else if (q.cnt == last)
    begin
      d.cnt = 7'h00;
      d.tick = 1'h1;
    end
    else
      d.cnt = q.cnt + 7'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign tick = q.tick;
endmodule

/* File: adc_trigger_select.sv */
`timescale 1ns/10ps
`include "adc_ctrl_params.svh"
module adc_trigger_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic auto_enable,
  input wire adc_ctrl_pkg::trig_sel_t trig_sel,
  input wire logic [6:0] trig_src,
  output logic trig_pulse
);
  import adc_ctrl_pkg::*;

  trig_state_t q;
  trig_state_t d;
  logic level;

  always_comb
  begin
    d = q;
    // Free running code selects a constant low, so switching to it never fires
    if (trig_sel == `TRIG_FREE_RUNNING)
      level = 1'h0;
    else
      level = trig_src[3'(trig_sel - 3'h1)];
    // Edge taken after the mux: a source switch low-to-high counts too
    d.prev = level;
    d.pulse = auto_enable & level & ~q.prev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else if (ce)
      q <= d;
  end

  assign trig_pulse = q.pulse;
endmodule

/* File: adc_conversion_control.sv */
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "adc_ctrl_params.svh"
module adc_conversion_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  input wire logic [6:0] trig_src,
  input wire logic [9:0] analog_result,
  output logic converter_power,
  output logic sample_start,
  output logic conversion_busy,
  output logic [1:0] reference_select_active,
  output logic [4:0] input_select_active,
  output logic done_irq
);
  import adc_ctrl_pkg::*;

  ctrl_state_t q;
  ctrl_state_t d;
  logic tick;
  logic trig_pulse;
  logic access;
  logic finish;
  logic hit;
  logic wr_csra;
  logic rd_low;
  logic rd_high;
  logic new_en;
  logic en_rise;
  logic conv_done;
  logic start_req;
  logic free_run;
  logic flag_clr;
  logic is_diff;
  logic [9:0] conv_value;
  logic [7:0] low_view;
  logic [7:0] high_view;
  logic [7:0] rd_byte;

  adc_clock_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(q.state == ST_CONV),
    .div_sel(q.div_sel),
    .tick(tick)
  );

  adc_trigger_select u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .auto_enable(q.auto_trig & q.en),
    .trig_sel(q.trig_sel),
    .trig_src(trig_src),
    .trig_pulse(trig_pulse)
  );

  always_comb
  begin
    // Views follow the alignment bit live, no conversion needed
    if (q.left)
    begin
      high_view = q.result[9:2];
      low_view = {q.result[1:0], 6'h00};
    end
    else
    begin
      high_view = {6'h00, q.result[9:8]};
      low_view = q.result[7:0];
    end
    hit = 1'h1;
    case (paddr)
      `OFS_CTRL_STATUS_A: rd_byte = {q.en, q.busy, q.auto_trig, q.flag, q.irq_en, q.div_sel};
      `OFS_RESULT_LOW: rd_byte = low_view;
      `OFS_RESULT_HIGH: rd_byte = high_view;
      `OFS_SPECIAL_FUNC: rd_byte = {q.trig_sel, q.sf_low};
      `OFS_INPUT_REF_SEL: rd_byte = {q.ref_sel, q.left, q.in_sel};
      default:
      begin
        rd_byte = 8'h00;
        hit = 1'h0;
      end
    endcase
  end

  always_comb
  begin
    d = q;
    d.start_pulse = 1'h0;
    access = psel & penable;
    finish = access & q.pready;
    // One wait state so read data leaves a flip-flop
    d.pready = access & ~q.pready;
    if (access & ~q.pready)
    begin
      d.prdata = {24'h000000, rd_byte};
      d.pslverr = ~hit;
    end
    wr_csra = finish & pwrite & (paddr == `OFS_CTRL_STATUS_A);
    rd_low = finish & ~pwrite & (paddr == `OFS_RESULT_LOW);
    rd_high = finish & ~pwrite & (paddr == `OFS_RESULT_HIGH);

    if (finish & pwrite)
    begin
      case (paddr)
        `OFS_CTRL_STATUS_A:
        begin
          d.en = pwdata[`BIT_ENABLE];
          d.auto_trig = pwdata[`BIT_AUTO];
          d.irq_en = pwdata[`BIT_IRQ_EN];
          d.div_sel = pwdata[2:0];
        end
        `OFS_SPECIAL_FUNC:
        begin
          d.trig_sel = pwdata[7:5];
          d.sf_low = pwdata[4:0];
        end
        `OFS_INPUT_REF_SEL:
        begin
          d.ref_sel = pwdata[7:6];
          d.left = pwdata[`BIT_LEFT_ALIGN];
          d.in_sel = pwdata[4:0];
        end
        default:
        begin
          d.lock = q.lock;
        end
      endcase
    end

    new_en = d.en;
    en_rise = new_en & ~q.en;
    if (en_rise)
      d.first = 1'h1;
    free_run = q.auto_trig & (q.trig_sel == `TRIG_FREE_RUNNING);
    conv_done = (q.state == ST_CONV) & tick &
                (q.cnt == (q.long_conv ? `CONV_TICKS_FIRST : `CONV_TICKS_NORMAL) - 5'h01);
    // Zero written to start does nothing; start only from idle
    start_req = (wr_csra & pwdata[`BIT_START]) | trig_pulse;

    is_diff = (q.act_in >= `DIFF_INPUT_FIRST) & (q.act_in <= `DIFF_INPUT_LAST);
    conv_value = is_diff ? {~analog_result[9], analog_result[8:0]} : analog_result;

    if (!new_en)
    begin
      // Abort drops the result and leaves the flag alone
      d.state = ST_IDLE;
      d.busy = 1'h0;
      d.cnt = 5'h00;
    end
    else
    begin
      case (q.state)
        ST_IDLE:
        begin
          if (start_req)
          begin
            d.state = ST_CONV;
            d.busy = 1'h1;
            d.cnt = 5'h00;
            d.long_conv = q.first | en_rise;
            d.first = 1'h0;
            d.start_pulse = 1'h1;
          end
        end
        ST_CONV:
        begin
          if (conv_done)
          begin
            // A locked result register drops this conversion's value
            if (!q.lock)
              d.result = conv_value;
            if (free_run)
            begin
              d.cnt = 5'h00;
              d.long_conv = 1'h0;
              d.start_pulse = 1'h1;
            end
            else
            begin
              d.state = ST_IDLE;
              d.busy = 1'h0;
            end
          end
          else if (tick)
            d.cnt = q.cnt + 5'h01;
        end
        default:
        begin
          d.state = ST_IDLE;
          d.busy = 1'h0;
        end
      endcase
    end

    // Selections are held for the running conversion
    if (q.state != ST_CONV || conv_done)
    begin
      d.act_ref = q.ref_sel;
      d.act_in = q.in_sel;
    end

    // Setting wins over a clear in the same cycle
    flag_clr = irq_vector_taken | (wr_csra & pwdata[`BIT_FLAG]);
    d.flag = (conv_done & new_en) | (q.flag & ~flag_clr);
    d.irq = q.flag & q.irq_en & global_irq_enable;

    if (rd_low)
      d.lock = 1'h1;
    else if (rd_high)
      d.lock = 1'h0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.result <= `RESET_RESULT;
    end
    else if (ce)
      q <= d;
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign converter_power = q.en;
  assign sample_start = q.start_pulse;
  assign conversion_busy = q.busy;
  assign reference_select_active = q.act_ref;
  assign input_select_active = q.act_in;
  assign done_irq = q.irq;

  sequence s_start_write;
    ce && q.state == ST_IDLE && wr_csra && pwdata[`BIT_START] && pwdata[`BIT_ENABLE];
  endsequence

  sequence s_conv_done;
    ce && conv_done && new_en;
  endsequence

  property p_disable_abort;
    @(posedge pclk) disable iff (!presetn)
    ce && q.busy && wr_csra && !pwdata[`BIT_ENABLE] |=> !q.busy && q.result == $past(q.result);
  endproperty
  a_disable_abort: assert property (p_disable_abort) else $error("conversion not aborted");

  property p_single_start;
    @(posedge pclk) disable iff (!presetn)
    s_start_write |=> q.busy && q.start_pulse && q.state == ST_CONV;
  endproperty
  a_single_start: assert property (p_single_start) else $error("start write lost");

  property p_first_long;
    @(posedge pclk) disable iff (!presetn)
    (s_start_write and !q.en) |=> q.long_conv;
  endproperty
  a_first_long: assert property (p_first_long) else $error("first conversion not long");

  property p_count_bound;
    @(posedge pclk) disable iff (!presetn)
    q.state == ST_CONV |-> q.cnt < (q.long_conv ? `CONV_TICKS_FIRST : `CONV_TICKS_NORMAL);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("conversion too long");

  property p_done_flag;
    @(posedge pclk) disable iff (!presetn)
    s_conv_done |=> q.flag && ($past(q.lock) || q.result == $past(conv_value));
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("flag or result missing");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    ce && q.flag && q.irq_en && global_irq_enable |=> done_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
    ce && q.flag && irq_vector_taken && !conv_done |=> !q.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_lock_hold;
    @(posedge pclk) disable iff (!presetn)
    ce && q.lock |=> q.result == $past(q.result);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked result changed");

  property p_free_run;
    @(posedge pclk) disable iff (!presetn)
    (s_conv_done and free_run) |=> q.state == ST_CONV && q.busy && q.cnt == 5'h00;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run did not restart");

  // A start while running must not restart the count
  property p_busy_no_restart;
    @(posedge pclk) disable iff (!presetn)
    ce && q.state == ST_CONV && !conv_done |=> !q.start_pulse;
  endproperty
  a_busy_no_restart: assert property (p_busy_no_restart) else $error("start taken while busy");

  property p_trig_start;
    @(posedge pclk) disable iff (!presetn)
    ce && trig_pulse && q.state == ST_IDLE && new_en |=> q.start_pulse && q.busy;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger start lost");

  property p_flag_keep;
    @(posedge pclk) disable iff (!presetn)
    ce && q.flag && !irq_vector_taken && !(wr_csra && pwdata[`BIT_FLAG]) |=> q.flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag lost without clear");

  property p_irq_off;
    @(posedge pclk) disable iff (!presetn)
    ce && !(q.flag && q.irq_en && global_irq_enable) |=> !done_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");
endmodule

/* File: adc_analog_model.sv */
`timescale 1ns/10ps
module adc_analog_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_start,
  input wire logic conversion_busy,
  input wire logic [9:0] level,
  output logic [9:0] analog_result
);
  logic [9:0] held_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      held_q <= 10'h000;
    else if (sample_start)
      held_q <= level;
  // Idle core shows no stale value
  assign analog_result = conversion_busy ? held_q : ~held_q;
endmodule

/* File: test_adc_conversion_control.sv */
`timescale 1ns/10ps
module test_adc_conversion_control;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, gie = 1, vec = 0;
  logic [7:0] paddr = 8'h00, rd, sv, sn;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic [6:0] trig = 7'h00;
  logic [9:0] raw = 10'h048, ares;
  logic pready, pslverr, err, pwr, sst, busy, irq;
  logic [1:0] ract;
  logic [4:0] iact;
  logic [15:0] ev;
  int samp_q[$];
  int n_mismatch = 0, samples_checked = 0, n_start = 0, blen = 0, s0;
  always #50 pclk = ~pclk;
  adc_conversion_control adc_conversion_control_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_irq_enable(gie), .irq_vector_taken(vec), .trig_src(trig),
    .analog_result(ares), .converter_power(pwr), .sample_start(sst), .conversion_busy(busy),
    .reference_select_active(ract), .input_select_active(iact), .done_irq(irq));
  adc_analog_model adc_analog_model_inst (.pclk(pclk), .presetn(presetn), .sample_start(sst),
    .conversion_busy(busy), .level(raw), .analog_result(ares));
  always @(posedge pclk)
  begin
    if (busy === 1'b1)
      blen++;
    if (sst === 1'b1)
    begin
      n_start++;
      samp_q.push_back(raw);
    end
  end
  function automatic logic [9:0] next_rand(input logic [9:0] s);
    return {s[8:0], s[9] ^ s[6]};
  endfunction
  function automatic logic [7:0] sel(input int c);
    return {c[1:0], c[0], c[1] ? 5'h08 : 5'h03};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    $display("ERROR %0t: wait ran out", $time);
    stop_test();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      hang();
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never re-raises psel in this step
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk({8'h00, rd}, {8'h00, e});
  endtask
  // Waits up to 50 edges for a start, then for the end; the 4000-edge total is generous vs 25*128
  task automatic conv;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (busy !== 1'b1)
      hang();
    while (busy === 1'b1 && n < 4000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 4000 || busy !== 1'b0)
      hang();
  endtask
  task automatic lchk(input int nn);
    chk(blen >= nn && blen <= nn + 1, 1'b1);
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 5; a++)
      rchk(8'(a * 4), 8'h00);
    apb(1'b0, 8'h14, 8'h00);
    chk({15'h0000, err}, 16'h0001);
    $display("test reset finished");
    apb(1'b1, 8'h10, sel(0));
    for (int c = 0; c < 8; c++)
    begin
      sv = sel(c);
      sn = sel(c + 1);
      raw <= next_rand(raw);
      s0 = n_start;
      blen = 0;
      apb(1'b1, 8'h00, 8'hD0 | 8'(c));
      apb(1'b1, 8'h10, sn);
      chk({ract, iact}, {sv[7:6], sv[4:0]});
      conv();
      lchk((c == 0 ? 25 : 13) * (c < 2 ? 2 : 1 << c));
      chk(n_start - s0, 1);
      rchk(8'h00, 8'h90 | 8'(c));
      chk({ract, iact}, {sn[7:6], sn[4:0]});
      ev = view(10'(samp_q[$]) ^ (c[1] ? 10'h200 : 10'h000), sn[5]);
      rchk(8'h04, ev[7:0]);
      rchk(8'h08, ev[15:8]);
    end
    $display("test divider finished");
    apb(1'b1, 8'h00, 8'h88);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    gie <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    gie <= 1'b1;
    vec <= 1'b1;
    @(posedge pclk);
    vec <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
    rchk(8'h00, 8'h88);
    $display("test interrupt finished");
    rchk(8'h04, ev[7:0]);
    raw <= next_rand(raw);
    apb(1'b1, 8'h00, 8'hC0);
    conv();
    rchk(8'h08, ev[15:8]);
    apb(1'b1, 8'h00, 8'hD0);
    conv();
    ev = view(10'(samp_q[$]), 1'b0);
    rchk(8'h04, ev[7:0]);
    rchk(8'h08, ev[15:8]);
    raw <= next_rand(raw);
    apb(1'b1, 8'h00, 8'hD0);
    repeat (5) @(posedge pclk);
    chk({pwr, busy}, 2'b11);
    apb(1'b1, 8'h00, 8'h00);
    repeat (2) @(posedge pclk);
    chk({pwr, busy}, 2'b00);
    rchk(8'h00, 8'h00);
    rchk(8'h04, ev[7:0]);
    rchk(8'h08, ev[15:8]);
    $display("test abort finished");
    apb(1'b1, 8'h0C, 8'h40);
    apb(1'b1, 8'h00, 8'h80);
    trig <= 7'h02;
    @(posedge pclk);
    trig <= 7'h00;
    repeat (6) @(posedge pclk);
    chk(busy, 1'b0);
    for (int k = 1; k < 8; k++)
    begin
      blen = 0;
      apb(1'b1, 8'h00, 8'hB0);
      // Odd codes: source already high when selected
      if (k % 2)
        trig <= 7'h01 << (k - 1);
      apb(1'b1, 8'h0C, {3'(k), 5'h00});
      trig <= 7'h01 << (k - 1);
      conv();
      trig <= 7'h00;
      lchk((k == 1 ? 25 : 13) * 2);
    end
    s0 = n_start;
    apb(1'b1, 8'h0C, 8'h00);
    repeat (10) @(posedge pclk);
    chk(n_start - s0, 0);
    $display("test trigger finished");
    s0 = n_start;
    apb(1'b1, 8'h00, 8'hF0);
    repeat (120) @(posedge pclk);
    chk(n_start - s0 >= 4 && n_start - s0 <= 5, 1'b1);
    apb(1'b1, 8'h00, 8'h00);
    repeat (2) @(posedge pclk);
    chk(pwr, 1'b0);
    $display("test free run finished");
    stop_test();
  end
  function automatic logic [15:0] view(input logic [9:0] r, input logic left);
    return left ? {r, 6'h00} : {6'h00, r};
  endfunction
endmodule
